/* rtl/olc_top.sv */
// Purpose: compose layer 1, layer 2 and sprite layer 3 into one pixel stream
// Assumes: a dot's layer pixels may arrive over several cycles up to its tick; hsync from a pin
// Notes:   register map over AHB-Lite; zero wait states
//
// Operation
// RL1: sprite blocks never drive the secondary digital output.
// RL2: window gating is ignored for sprite pixels.
// RL3: extended mode raises a line-end pulse so software rewrites a block.
// RL4: block layer target comes from control2 bit 0 or 1 per mode.
// RL5: layer 3 carries only the sprite, never character blocks.
// RL6: overlapping layer 1 and 2 are mixed per control1 bits 6 and 7.
// RL7: sprite pixel always wins over layers 1 and 2.
// RL8: pattern mode always goes to layer 1; software avoids overlap.
// RL9: secondary output is OR of layers 1 and 2, unmasked by sprite.
// RL10: software limits layer 2 to font or colour-dot modes.
// RL11: software picks pre-divide x1-x2 caption, x1-x3 otherwise.
// RL12: layer 2 pre-divide must equal layer 1 pre-divide.
// RL13: caption uses only 1 dot by half-line or one-line sizes.
// RL14: overlapping layer 2 uses layer 1 dot size except 1.5 dot case.
// RL15: layer 2 1.5 dot width only with layer 1 x2 and 1 dot.
// RL16: with 1.5 dot width layer 2 vertical size equals layer 1.
// RL17: layer 2 starts at layer 1 horizontal position.
// RL18: vertical start offsets in multiples of 2 or 3 lines.
// RL19: large font never uses 1.5 dot width.
// RL20: dot clock is the oscillator divided by pre-divide ratio.
// RL21: software never uses pre-divide three in caption mode.
// RL22: all three layers are aligned to one dot cycle before mixing.
`timescale 1ns/1ns
`default_nettype none
module olc_top
  import olc_pkg::*;
(
  // system
  input  wire logic             CLK_SYS,
  input  wire logic             RESETN,
  // ahb-lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  // dot enable from pre-divider and line sync pin
  input  wire logic             DOT_EN,
  input  wire logic             HSYNC_PIN,
  // current block and its layer pixels
  input  wire olc_pkg::olc_mode_t BLK_MODE,
  input  wire olc_pkg::olc_pix_t  CHAR_PIX,
  input  wire olc_pkg::olc_pix_t  SPR_PIX,
  input  wire logic             WINDOW_ON,
  // video out
  output olc_pkg::olc_pix_t     PIX_OUT,
  output logic                  SECONDARY_DIGITAL_OUTPUT,
  output logic                  LINE_DONE
);
  import olc_pkg::*;

  // layer choice per mode from control2 bit 0 or bit 1
  function automatic logic to_layer2(input olc_mode_t m, input logic [7:0] c2);
    case (m)
      MD_FONT:    to_layer2 = c2[0];
      MD_CDOT:    to_layer2 = c2[1];
      default:    to_layer2 = 1'b0;
    endcase
  endfunction

  // bus registers
  logic [7:0]  ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, mode_q, mode_d;
  logic        ph_wr_q, ph_wr_d;
  olc_state_t  st_q, st_d;
  logic [15:0] line_cnt_q, line_cnt_d;
  logic [7:0]  ph_a_q, ph_a_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ah_ok;
  assign ah_ok = HSEL && HREADY && HTRANS[1];

  always_comb
  begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    mode_d  = mode_q;
    ph_wr_d = ah_ok && HWRITE;
    ph_a_d  = ah_ok ? HADDR[7:0] : ph_a_q;
    rdata_d = 32'h0000_0000;
    if (ph_wr_q)
    begin
      case (ph_a_q)
        OFF_CTRL1: ctrl1_d = HWDATA[7:0];
        OFF_CTRL2: ctrl2_d = HWDATA[7:0];
        OFF_MODE:  mode_d  = HWDATA[7:0];
        default:   ;
      endcase
    end
    if (ah_ok && !HWRITE)
    begin
      case (HADDR[7:0])
        OFF_CTRL1:  rdata_d = {24'h00_0000, ctrl1_q};
        OFF_CTRL2:  rdata_d = {24'h00_0000, ctrl2_q};
        OFF_MODE:   rdata_d = {24'h00_0000, mode_q};
        OFF_STATUS: rdata_d = {29'h0000_0000, st_q};
        OFF_LINE:   rdata_d = {16'h0000, line_cnt_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // hsync pin: three flops, rise when second and third agree on a change to high
  logic [HS_SYNC_N-1:0] hs_q, hs_d;
  logic                 hs_lvl_q, hs_lvl_d, hs_rise;
  always_comb
  begin
    hs_d     = {hs_q[HS_SYNC_N-2:0], HSYNC_PIN};
    hs_lvl_d = (hs_q[1] == hs_q[2]) ? hs_q[2] : hs_lvl_q;
    hs_rise  = (hs_q[1] == hs_q[2]) && hs_q[2] && !hs_lvl_q;
  end

  // extended mode line sequencer
  logic        done_q, done_d;
  always_comb
  begin
    st_d       = st_q;
    line_cnt_d = line_cnt_q;
    done_d     = 1'b0;
    case (st_q)
      ST_IDLE: if (mode_q[0]) st_d = ST_LINE;
      ST_LINE:
        if (!mode_q[0])
          st_d = ST_IDLE;
        else if (hs_rise)
        begin
          st_d       = ST_DONE;
          done_d     = 1'b1; // RL3
          line_cnt_d = line_cnt_q + 16'h0001;
        end
      ST_DONE: st_d = ST_LINE;
      default: st_d = ST_IDLE;
    endcase
  end

  // compositor: gather each layer over the dot, align on the tick, then mix,
  // so priority and OR decisions always see coincident pixels
  olc_pix_t g1_q, g1_d, g2_q, g2_d, g3_q, g3_d, c1, c2, c3, in_pix;
  olc_pix_t l1_q, l1_d, l2_q, l2_d, l3_q, l3_d, out_q, out_d;
  logic     o2_q, o2_d;
  always_comb
  begin
    // window gates character pixels only; a later lit pixel replaces an earlier one
    in_pix    = CHAR_PIX;
    in_pix.on = CHAR_PIX.on && WINDOW_ON;
    c1        = g1_q;
    c2        = g2_q;
    c3        = g3_q;
    if (BLK_MODE == MD_SPRITE)
    begin
      if (SPR_PIX.on)
        c3 = SPR_PIX; // RL5 RL2
    end
    else if (in_pix.on)
    begin
      if (to_layer2(BLK_MODE, ctrl2_q)) // RL4 RL8
        c2 = in_pix;
      else
        c1 = in_pix;
    end
    g1_d  = c1;
    g2_d  = c2;
    g3_d  = c3;
    l1_d  = l1_q;
    l2_d  = l2_q;
    l3_d  = l3_q;
    out_d = out_q;
    o2_d  = o2_q;
    if (DOT_EN) // RL20
    begin
      // all layers handed on together on the same dot edge
      l1_d = c1; // RL22
      l2_d = c2;
      l3_d = c3;
      g1_d = '0;
      g2_d = '0;
      g3_d = '0;
      o2_d = l1_q.on | l2_q.on; // RL9 RL1
      if (l3_q.on)
        out_d = l3_q; // RL7
      else if (l1_q.on && l2_q.on)
      begin
        case ({ctrl1_q[MIX_B1], ctrl1_q[MIX_B0]}) // RL6
          2'b00:   out_d = l1_q;
          2'b01:   out_d = l2_q;
          2'b10:   out_d = '{on: 1'b1, color: l1_q.color | l2_q.color};
          default: out_d = '{on: 1'b1, color: l1_q.color ^ l2_q.color};
        endcase
      end
      else if (l1_q.on)
        out_d = l1_q;
      else
        out_d = l2_q;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      mode_q <= MODE_RST;
      ph_wr_q <= 1'b0;
      ph_a_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      hs_q <= '0;
      hs_lvl_q <= 1'b0;
      st_q <= ST_IDLE;
      line_cnt_q <= 16'h0000;
      done_q <= 1'b0;
      g1_q <= '0;
      g2_q <= '0;
      g3_q <= '0;
      l1_q <= '0;
      l2_q <= '0;
      l3_q <= '0;
      out_q <= '0;
      o2_q <= 1'b0;
    end
    else
    begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      mode_q <= mode_d;
      ph_wr_q <= ph_wr_d;
      ph_a_q <= ph_a_d;
      rdata_q <= rdata_d;
      hs_q <= hs_d;
      hs_lvl_q <= hs_lvl_d;
      st_q <= st_d;
      line_cnt_q <= line_cnt_d;
      done_q <= done_d;
      g1_q <= g1_d;
      g2_q <= g2_d;
      g3_q <= g3_d;
      l1_q <= l1_d;
      l2_q <= l2_d;
      l3_q <= l3_d;
      out_q <= out_d;
      o2_q <= o2_d;
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign PIX_OUT   = out_q;
  assign SECONDARY_DIGITAL_OUTPUT = o2_q;
  assign LINE_DONE = done_q;

  property p_sprite_wins;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (DOT_EN && l3_q.on) |=> (PIX_OUT == $past(l3_q));
  endproperty
  a_sprite_wins: assert property (p_sprite_wins) else $error("sprite lost"); // RL7

  property p_or_out;
    @(posedge CLK_SYS) disable iff (!RESETN)
    DOT_EN |=> (SECONDARY_DIGITAL_OUTPUT == ($past(l1_q.on) | $past(l2_q.on)));
  endproperty
  a_or_out: assert property (p_or_out) else $error("secondary not or"); // RL9

  property p_no_sprite_o2;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (DOT_EN && BLK_MODE == MD_SPRITE) |=> (l1_q == $past(g1_q)) && (l2_q == $past(g2_q));
  endproperty
  a_no_sprite_o2: assert property (p_no_sprite_o2) else $error("sprite in char layer"); // RL1

  property p_window;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (DOT_EN && BLK_MODE == MD_SPRITE && SPR_PIX.on) |=> (l3_q == $past(SPR_PIX));
  endproperty
  a_window: assert property (p_window) else $error("sprite gated"); // RL2

  property p_line;
    @(posedge CLK_SYS) disable iff (!RESETN)
    LINE_DONE |-> (st_q == ST_DONE) ##1 (st_q == ST_LINE || st_q == ST_IDLE);
  endproperty
  a_line: assert property (p_line) else $error("line pulse bad"); // RL3

  property p_layer_sel;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (DOT_EN && BLK_MODE == MD_FONT && CHAR_PIX.on && WINDOW_ON && ctrl2_q[0])
      |=> (l2_q == $past(CHAR_PIX)) && (l1_q == $past(g1_q));
  endproperty
  a_layer_sel: assert property (p_layer_sel) else $error("layer select"); // RL4

  property p_pattern;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (DOT_EN && BLK_MODE == MD_PATTERN && CHAR_PIX.on && WINDOW_ON)
      |=> (l1_q == $past(CHAR_PIX)) && (l2_q == $past(g2_q)) && (l3_q == $past(g3_q));
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern off layer1"); // RL8

  property p_mix;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (DOT_EN && !l3_q.on && l1_q.on && l2_q.on && ctrl1_q[7:6] == 2'b01)
      |=> (PIX_OUT == $past(l2_q));
  endproperty
  a_mix: assert property (p_mix) else $error("mix select"); // RL6
endmodule // olc_top
`default_nettype wire

/* rtl/olc_pkg.sv */
// Purpose: shared constants and types for the display layer compositor
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes:   offsets are byte addresses
package olc_pkg;
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_MODE   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_LINE   = 8'h10;
  localparam int         MIX_B0     = 6;
  localparam int         MIX_B1     = 7;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam int         HS_SYNC_N  = 3;
  localparam int         PIPE_N     = 2;

  // display mode of a block
  typedef enum logic [2:0]
  {
    MD_CAPTION = 3'h0,
    MD_FONT    = 3'h1,
    MD_CDOT    = 3'h2,
    MD_PATTERN = 3'h3,
    MD_SPRITE  = 3'h4
  } olc_mode_t;

  // one layer pixel: on flag and 4-bit colour code
  typedef struct packed
  {
    logic       on;
    logic [3:0] color;
  } olc_pix_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_LINE = 3'b010,
    ST_DONE = 3'b100
  } olc_state_t;
endpackage

/* tb/olc_tv_model.sv */
// Purpose: far-side video model that makes line sync and counts the lines it sent
// Assumes: hsync is a free-running pin, unrelated in phase to the system clock
// Notes:   pulses only while run is high, so the bench can stop the lines
`timescale 1ns/1ns
`default_nettype none
module olc_tv_model
(
  // control
  input  wire logic run,
  // sync pin and count of lines sent
  output logic      hsync,
  output int        pulses
);
  initial
  begin
    hsync  = 1'b0;
    pulses = 0;
  end
  // odd offsets keep edges off the clock grid to exercise the synchroniser
  always
  begin
    #1737;
    if (run)
    begin
      hsync = 1'b1;
      pulses = pulses + 1;
      #837 hsync = 1'b0;
    end
  end
endmodule // olc_tv_model
`default_nettype wire

/* tb/olc_top_tb.sv */
// Purpose: self-checking bench for the layer compositor
// Assumes: zero-wait AHB-Lite slave, pixel result one dot tick after the tick that takes it
// Notes:   layer pixels of one dot arrive over several cycles, so layers 1 and 2 overlap
`timescale 1ns/1ns
`default_nettype none
module olc_top_tb;
  import olc_pkg::*;
  localparam int LAT = PIPE_N;
  logic        CLK_SYS, RESETN, HSEL, HWRITE, HREADY, DOT_EN, WINDOW_ON, run;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic        HREADYOUT, HRESP, SECONDARY_DIGITAL_OUTPUT, LINE_DONE, HSYNC_PIN;
  olc_mode_t   BLK_MODE;
  olc_pix_t    CHAR_PIX, SPR_PIX, PIX_OUT;
  logic [5:0]  q[$];
  logic [1:0]  mixc, sel;
  int          mismatches, check_count, cycles, seed, pulses, dones;
  assign HREADY = HREADYOUT;
  olc_top olc_top_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DOT_EN(DOT_EN),
    .HSYNC_PIN(HSYNC_PIN), .BLK_MODE(BLK_MODE), .CHAR_PIX(CHAR_PIX), .SPR_PIX(SPR_PIX),
    .WINDOW_ON(WINDOW_ON), .PIX_OUT(PIX_OUT),
    .SECONDARY_DIGITAL_OUTPUT(SECONDARY_DIGITAL_OUTPUT), .LINE_DONE(LINE_DONE));
  olc_tv_model olc_tv_model_inst (.run(run), .hsync(HSYNC_PIN), .pulses(pulses));
  always #50 CLK_SYS = ~CLK_SYS;
  task end_sim();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (LINE_DONE === 1'b1)
      dones++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one single word transfer; the bus answers whenever it raises ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1; HADDR <= {24'h0, a}; HTRANS <= 2'b10; HWRITE <= w; HSIZE <= 3'h2;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0; HTRANS <= 2'b00; HWDATA <= wd;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    check({31'h0, HRESP}, 32'h0);
  endtask
  // layer model: each layer keeps its latest lit pixel until the tick hands all
  // three on; the mix shows after the following tick
  task stream(input int n);
    olc_pix_t    p, g1, g2, g3;
    logic [5:0]  e;
    logic [31:0] got;
    logic        chk, to2;
    q.delete();
    g1 = '0;
    g2 = '0;
    g3 = '0;
    repeat (n)
    begin
      @(posedge CLK_SYS);
      chk  = 1'b0;
      p    = CHAR_PIX;
      p.on = CHAR_PIX.on & WINDOW_ON;
      to2  = (BLK_MODE == MD_FONT && sel[0]) || (BLK_MODE == MD_CDOT && sel[1]);
      if (BLK_MODE == MD_SPRITE)
      begin
        if (SPR_PIX.on)
          g3 = SPR_PIX;
      end
      else if (p.on && to2)
        g2 = p;
      else if (p.on)
        g1 = p;
      if (DOT_EN)
      begin
        e[5] = g1.on | g2.on;
        if (g3.on)
          e[4:0] = g3;
        else if (g1.on && g2.on)
        begin
          case (mixc)
            2'b00:   e[4:0] = g1;
            2'b01:   e[4:0] = g2;
            2'b10:   e[4:0] = {1'b1, g1.color | g2.color};
            default: e[4:0] = {1'b1, g1.color ^ g2.color};
          endcase
        end
        else if (g1.on)
          e[4:0] = g1;
        else
          e[4:0] = g2;
        q.push_back(e);
        chk = (q.size() >= LAT);
        g1  = '0;
        g2  = '0;
        g3  = '0;
      end
      // one tick for every layer keeps them on one pre-divide ratio, dot grid and start
      DOT_EN    <= 1'($random(seed));
      WINDOW_ON <= 1'($random(seed));
      SPR_PIX   <= 5'($random(seed));
      BLK_MODE  <= olc_mode_t'(3'({$random(seed)} % 5));
      CHAR_PIX  <= 5'($random(seed));
      @(negedge CLK_SYS);
      if (chk)
      begin
        got = {26'h0, SECONDARY_DIGITAL_OUTPUT, PIX_OUT};
        check(got, {26'h0, q.pop_front()});
      end
    end
    // quiet inputs with the tick held so both stages are empty before the next run
    @(posedge CLK_SYS);
    DOT_EN   <= 1'b1;
    CHAR_PIX <= '0;
    SPR_PIX  <= '0;
  endtask
  initial
  begin
    CLK_SYS = 1'b0; RESETN = 1'b0; HSEL = 1'b0; HADDR = '0; HTRANS = 2'b00; HWRITE = 1'b0;
    HSIZE = 3'h2; HWDATA = '0; DOT_EN = 1'b0; WINDOW_ON = 1'b0; BLK_MODE = MD_CAPTION;
    CHAR_PIX = '0; SPR_PIX = '0; run = 1'b0; seed = 10;
    mismatches = 0; check_count = 0; cycles = 0; dones = 0;
    repeat (5) @(posedge CLK_SYS);
    check({HREADYOUT, LINE_DONE, SECONDARY_DIGITAL_OUTPUT, PIX_OUT}, 32'h80);
    RESETN <= 1'b1;
    @(posedge CLK_SYS);
    bus(1'b0, OFF_CTRL1, 32'h0); check(rd, {24'h0, CTRL1_RST});
    bus(1'b0, OFF_CTRL2, 32'h0); check(rd, {24'h0, CTRL2_RST});
    bus(1'b0, OFF_MODE, 32'h0); check(rd, {24'h0, MODE_RST});
    bus(1'b0, OFF_LINE, 32'h0); check(rd, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'(ST_IDLE));
    bus(1'b1, 8'h20, 32'hffff_ffff);
    bus(1'b0, 8'h20, 32'h0); check(rd, 32'h0);
    // every mixing code, each with a random layer choice per mode
    for (int m = 0; m < 4; m++)
    begin
      mixc = 2'(m);
      // keep at least one mode routed to layer 2 so the layers can overlap
      sel = 2'($random(seed));
      if (sel == 2'b00)
        sel = 2'b10;
      bus(1'b1, OFF_CTRL1, 32'(m << MIX_B0));
      bus(1'b0, OFF_CTRL1, 32'h0); check(rd, 32'(m << MIX_B0));
      bus(1'b1, OFF_CTRL2, {30'h0, sel});
      bus(1'b0, OFF_CTRL2, 32'h0);
      check(rd, {30'h0, sel});
      stream(300);
    end
    bus(1'b1, OFF_MODE, 32'h1);
    dones = 0;
    run = 1'b1;
    repeat (300) @(posedge CLK_SYS);
    run = 1'b0;
    repeat (60) @(posedge CLK_SYS);
    check(32'(dones), 32'(pulses));
    bus(1'b0, OFF_LINE, 32'h0); check(rd, 32'(pulses));
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'(ST_LINE));
    bus(1'b1, OFF_MODE, 32'h0);
    dones = 0;
    run = 1'b1;
    repeat (200) @(posedge CLK_SYS);
    run = 1'b0;
    repeat (60) @(posedge CLK_SYS);
    check(32'(dones), 32'h0);
    end_sim();
  end
endmodule // olc_top_tb
`default_nettype wire
